// ==== hw/global_irq_status_mask.sv ====
// global interrupt aggregation: per-source summary, per-channel enables, combined output
`timescale 1ns/1ps
`default_nettype none
module global_irq_status_mask
  import irq_agg_pkg::*;
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // register port
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // sub-unit interrupt request levels, one bit per channel
  input wire logic [3:0] i_framer_irq,
  input wire logic [3:0] i_tester_irq,
  input wire logic [3:0] i_line_if_irq,
  input wire logic [3:0] i_hdlc_irq,
  // combined host interrupt, active high
  output logic o_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // request synchronisers: three stages, a change counts when stages 2 and 3 agree
  logic [3:0] sync1 [4];
  logic [3:0] sync2 [4];
  logic [3:0] sync3 [4];
  logic [3:0] req_in [4];
  logic [3:0] framer_irq_summary;
  logic [3:0] tester_irq_summary;
  logic [3:0] line_if_irq_summary;
  logic [3:0] hdlc_irq_summary;

  assign req_in[0] = i_framer_irq;
  assign req_in[1] = i_tester_irq;
  assign req_in[2] = i_line_if_irq;
  assign req_in[3] = i_hdlc_irq;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_sync
      always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
          sync1[g] <= SYNC_RESET;
          sync2[g] <= SYNC_RESET;
          sync3[g] <= SYNC_RESET;
        end else begin
          sync1[g] <= req_in[g];
          sync2[g] <= sync1[g];
          sync3[g] <= sync2[g];
        end
      end
    end
  endgenerate

  // summaries follow the request levels, no latching
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      framer_irq_summary <= SUMMARY_RESET;
      tester_irq_summary <= SUMMARY_RESET;
      line_if_irq_summary <= SUMMARY_RESET;
      hdlc_irq_summary <= SUMMARY_RESET;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (sync2[0][c] == sync3[0][c]) framer_irq_summary[c] <= sync3[0][c];
        if (sync2[1][c] == sync3[1][c]) tester_irq_summary[c] <= sync3[1][c];
        if (sync2[2][c] == sync3[2][c]) line_if_irq_summary[c] <= sync3[2][c];
        if (sync2[3][c] == sync3[3][c]) hdlc_irq_summary[c] <= sync3[3][c];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // enable registers
  logic [3:0] framer_irq_enable;
  logic [3:0] tester_irq_enable;
  logic [3:0] line_if_irq_enable;
  logic [3:0] hdlc_irq_enable;

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      framer_irq_enable <= ENABLE_RESET;
      tester_irq_enable <= ENABLE_RESET;
      line_if_irq_enable <= ENABLE_RESET;
      hdlc_irq_enable <= ENABLE_RESET;
    end else if (i_wr) begin
      case (i_addr)
        OFS_FRAMER_ENABLE: framer_irq_enable <= i_wdata[CH_MSB:CH_LSB];
        OFS_TESTER_ENABLE: tester_irq_enable <= i_wdata[CH_MSB:CH_LSB];
        OFS_LINE_ENABLE: line_if_irq_enable <= i_wdata[CH_MSB:CH_LSB];
        OFS_HDLC_ENABLE: hdlc_irq_enable <= i_wdata[CH_MSB:CH_LSB];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path: data one cycle after the strobe, zero otherwise and when unmapped
  logic [7:0] next_rdata;

  always_comb begin
    next_rdata = RDATA_RESET;
    if (i_rd) begin
      case (i_addr)
        OFS_HDLC_SUMMARY: next_rdata = {4'h0, hdlc_irq_summary};
        OFS_FRAMER_SUMMARY: next_rdata = {4'h0, framer_irq_summary};
        OFS_TESTER_SUMMARY: next_rdata = {4'h0, tester_irq_summary};
        OFS_LINE_SUMMARY: next_rdata = {4'h0, line_if_irq_summary};
        OFS_FRAMER_ENABLE: next_rdata = {4'h0, framer_irq_enable};
        OFS_TESTER_ENABLE: next_rdata = {4'h0, tester_irq_enable};
        OFS_LINE_ENABLE: next_rdata = {4'h0, line_if_irq_enable};
        OFS_HDLC_ENABLE: next_rdata = {4'h0, hdlc_irq_enable};
        default: next_rdata = RDATA_RESET;
      endcase
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) o_rdata <= RDATA_RESET;
    else o_rdata <= next_rdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // combined interrupt
  logic next_irq;
  assign next_irq = |((framer_irq_summary & framer_irq_enable) |
                      (tester_irq_summary & tester_irq_enable) |
                      (line_if_irq_summary & line_if_irq_enable) |
                      (hdlc_irq_summary & hdlc_irq_enable));

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) o_irq <= 1'b0;
    else o_irq <= next_irq;
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  property p_irq_follows;
    @(posedge i_clock) disable iff (i_rst)
      1'b1 |=> (o_irq == $past(next_irq));
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("irq not combined");

  property p_masked_quiet;
    @(posedge i_clock) disable iff (i_rst)
      (framer_irq_enable == 4'h0 && tester_irq_enable == 4'h0 &&
       line_if_irq_enable == 4'h0 && hdlc_irq_enable == 4'h0) |=> !o_irq;
  endproperty
  a_masked_quiet: assert property (p_masked_quiet) else $error("irq while all masked");

  property p_framer_enabled;
    @(posedge i_clock) disable iff (i_rst)
      (|(framer_irq_summary & framer_irq_enable)) |=> o_irq;
  endproperty
  a_framer_enabled: assert property (p_framer_enabled) else $error("framer request lost");

  property p_tester_enabled;
    @(posedge i_clock) disable iff (i_rst)
      (|(tester_irq_summary & tester_irq_enable)) |=> o_irq;
  endproperty
  a_tester_enabled: assert property (p_tester_enabled) else $error("tester request lost");

  property p_line_enabled;
    @(posedge i_clock) disable iff (i_rst)
      (|(line_if_irq_summary & line_if_irq_enable)) |=> o_irq;
  endproperty
  a_line_enabled: assert property (p_line_enabled) else $error("line request lost");

  property p_framer_en_write;
    @(posedge i_clock) disable iff (i_rst)
      (i_wr && i_addr == OFS_FRAMER_ENABLE) |=> (framer_irq_enable == $past(i_wdata[3:0]));
  endproperty
  a_framer_en_write: assert property (p_framer_en_write) else $error("framer enable");

  property p_tester_en_write;
    @(posedge i_clock) disable iff (i_rst)
      (i_wr && i_addr == OFS_TESTER_ENABLE) |=> (tester_irq_enable == $past(i_wdata[3:0]));
  endproperty
  a_tester_en_write: assert property (p_tester_en_write) else $error("tester enable");

  property p_line_en_write;
    @(posedge i_clock) disable iff (i_rst)
      (i_wr && i_addr == OFS_LINE_ENABLE) |=> (line_if_irq_enable == $past(i_wdata[3:0]));
  endproperty
  a_line_en_write: assert property (p_line_en_write) else $error("line enable");

  property p_framer_read;
    @(posedge i_clock) disable iff (i_rst)
      (i_rd && i_addr == OFS_FRAMER_SUMMARY) |=> (o_rdata == {4'h0, $past(framer_irq_summary)});
  endproperty
  a_framer_read: assert property (p_framer_read) else $error("framer summary read");

  property p_tester_read;
    @(posedge i_clock) disable iff (i_rst)
      (i_rd && i_addr == OFS_TESTER_SUMMARY) |=> (o_rdata == {4'h0, $past(tester_irq_summary)});
  endproperty
  a_tester_read: assert property (p_tester_read) else $error("tester summary read");

  property p_tester_level;
    @(posedge i_clock) disable iff (i_rst)
      (sync3[1][1:0] == sync2[1][1:0]) |=> (tester_irq_summary[1:0] == $past(sync3[1][1:0]));
  endproperty
  a_tester_level: assert property (p_tester_level) else $error("tester bits 1,0");

  property p_line_read;
    @(posedge i_clock) disable iff (i_rst)
      (i_rd && i_addr == OFS_LINE_SUMMARY) |=> (o_rdata == {4'h0, $past(line_if_irq_summary)});
  endproperty
  a_line_read: assert property (p_line_read) else $error("line summary read");

  property p_hdlc_ro;
    @(posedge i_clock) disable iff (i_rst)
      (i_rd && i_addr == OFS_HDLC_SUMMARY) |=> (o_rdata == {4'h0, $past(hdlc_irq_summary)});
  endproperty
  a_hdlc_ro: assert property (p_hdlc_ro) else $error("hdlc summary read");

endmodule
`default_nettype wire

// ==== include/irq_agg_pkg.sv ====
// package: register offsets, field layout and reset values of the global interrupt block
package irq_agg_pkg;
  localparam int NUM_CH = 4;
  localparam logic [15:0] OFS_HDLC_SUMMARY = 16'h00f5;
  localparam logic [15:0] OFS_HDLC_ENABLE = 16'h00f7;
  localparam logic [15:0] OFS_FRAMER_SUMMARY = 16'h00f9;
  localparam logic [15:0] OFS_TESTER_SUMMARY = 16'h00fa;
  localparam logic [15:0] OFS_LINE_SUMMARY = 16'h00fb;
  localparam logic [15:0] OFS_FRAMER_ENABLE = 16'h00fc;
  localparam logic [15:0] OFS_TESTER_ENABLE = 16'h00fd;
  localparam logic [15:0] OFS_LINE_ENABLE = 16'h00fe;
  localparam int CH_LSB = 0;
  localparam int CH_MSB = 3;
  localparam logic [3:0] ENABLE_RESET = 4'h0;
  localparam logic [3:0] SUMMARY_RESET = 4'h0;
  localparam logic [7:0] RDATA_RESET = 8'h00;
  localparam logic [3:0] SYNC_RESET = 4'h0;
endpackage

// ==== verification/global_irq_status_mask_tb_top.sv ====
// testbench for the global interrupt summary and enable block
`timescale 1ns/1ps
`default_nettype none
module global_irq_status_mask_tb_top
  import irq_agg_pkg::*;
;
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic [15:0] i_addr = 16'h0000;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [3:0] src [4] = '{4'h0, 4'h0, 4'h0, 4'h0};
  logic [7:0] o_rdata;
  logic o_irq;
  int failures = 0;
  int samples_checked = 0;
  logic [15:0] ena [4] = '{OFS_FRAMER_ENABLE, OFS_TESTER_ENABLE, OFS_LINE_ENABLE, OFS_HDLC_ENABLE};
  logic [15:0] sum [4] = '{OFS_FRAMER_SUMMARY, OFS_TESTER_SUMMARY, OFS_LINE_SUMMARY,
    OFS_HDLC_SUMMARY};
  always #5 i_clock = ~i_clock;
  global_irq_status_mask dut (.i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_framer_irq(src[0]), .i_tester_irq(src[1]), .i_line_if_irq(src[2]),
    .i_hdlc_irq(src[3]), .o_irq(o_irq));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask
  task automatic rdchk(input logic [15:0] a, input logic [7:0] exp);
    @(posedge i_clock);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_rd <= 1'b0;
    @(negedge i_clock);
    check($sformatf("reg %h", a), exp, o_rdata);
    @(negedge i_clock);
    check("o_rdata idle", 8'h00, o_rdata);
  endtask
  task automatic irqchk(input logic exp, input int wait_cycles);
    repeat (wait_cycles) @(posedge i_clock);
    @(negedge i_clock);
    check("o_irq", {7'h00, exp}, {7'h00, o_irq});
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // all registers zero after reset, unmapped reads zero
  task automatic t_reset();
    for (int k = 0; k < 4; k++) begin
      rdchk(ena[k], 8'h00);
      rdchk(sum[k], 8'h00);
    end
    rdchk(16'h00ff, 8'h00);
    irqchk(1'b0, 0);
  endtask
  // enables store bits 3:0; summaries and unmapped places refuse writes
  task automatic t_enable();
    for (int k = 0; k < 4; k++) begin
      wr(ena[k], 8'hf5);
      rdchk(ena[k], 8'h05);
      wr(sum[k], 8'hff);
      rdchk(sum[k], 8'h00);
    end
    wr(16'h00ff, 8'hff);
    rdchk(16'h00ff, 8'h00);
    irqchk(1'b0, 3);
    for (int k = 0; k < 4; k++) wr(ena[k], 8'h00);
  endtask
  // each summary bit follows its channel's level, without latching
  task automatic t_summary();
    for (int c = 0; c < 4; c++) begin
      @(posedge i_clock);
      for (int k = 0; k < 4; k++) src[k] <= 4'h1 << ((c + k) % 4);
      repeat (6) @(posedge i_clock);
      for (int k = 0; k < 4; k++) rdchk(sum[k], 8'h01 << ((c + k) % 4));
    end
    @(posedge i_clock);
    for (int k = 0; k < 4; k++) src[k] <= 4'h0;
    repeat (6) @(posedge i_clock);
    for (int k = 0; k < 4; k++) rdchk(sum[k], 8'h00);
    irqchk(1'b0, 0);
  endtask
  // combined output only for requests whose enable bit is 1
  task automatic t_mask();
    for (int k = 0; k < 4; k++) begin
      @(posedge i_clock);
      src[k] <= 4'h6;
      wr(ena[k], 8'h09);
      irqchk(1'b0, 6);
      wr(ena[k], 8'h04);
      irqchk(1'b1, 3);
      @(posedge i_clock);
      src[k] <= 4'h2;
      irqchk(1'b0, 6);
      wr(ena[k], 8'h00);
    end
    wr(OFS_LINE_ENABLE, 8'h0f);
    irqchk(1'b1, 2);
    @(posedge i_clock);
    i_rst <= 1'b1;
    @(posedge i_clock);
    irqchk(1'b0, 0);
    @(posedge i_clock);
    i_rst <= 1'b0;
    rdchk(OFS_LINE_ENABLE, 8'h00);
    irqchk(1'b0, 6);
    rdchk(OFS_LINE_SUMMARY, 8'h02);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge i_clock);
    i_rst <= 1'b0;
    t_reset();
    t_enable();
    t_summary();
    t_mask();
    stop_test();
  end
  initial begin
    repeat (20000) @(posedge i_clock);
    failures++;
    stop_test();
  end
endmodule
`default_nettype wire
